// ===== logic/sac_ctrl.sv
// conversion sequencer, result latches and power-down control
`include "sac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl #(
   parameter int RES_BITS = `SAC_RES_BITS,
   parameter int BIT_CYC = `SAC_BIT_CYC,
   parameter int LEAD_CYC = `SAC_LEAD_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic chip_select_n,
   input wire logic conversion_start_n,
   input wire logic read_n,
   input wire logic power_down_n,
   input wire logic shutdown_depth_select,
   input wire logic comparator_high,
   output logic busy_n,
   output logic [RES_BITS-1:0] result_bus_o,
   output logic [RES_BITS-1:0] result_bus_oe,
   output logic [RES_BITS-1:0] dac_word,
   output logic sample_phase,
   output logic [1:0] power_mode
);
   import sac_pkg::*;

   initial begin
      if (RES_BITS < 2 || RES_BITS > 16) $error("sac_ctrl: RES_BITS out of range");
      if (BIT_CYC < 1 || BIT_CYC > 255) $error("sac_ctrl: BIT_CYC out of range");
      if (LEAD_CYC < 1 || LEAD_CYC > 255) $error("sac_ctrl: LEAD_CYC out of range");
   end

   localparam logic [3:0] LAST_BIT = 4'(RES_BITS - 1);
   localparam logic [7:0] BIT_LAST = 8'(BIT_CYC - 1);
   localparam logic [7:0] LEAD_LAST = 8'(LEAD_CYC - 1);

   // synchronised pins: cs, start, read, shutdown, depth
   logic [4:0] pins_s;
   sac_sync #(.WIDTH(5), .RST_VAL(`SAC_PIN_IDLE)) i_sac_sync (
      .mclk(mclk),
      .reset(reset),
      .clk_en(clk_en),
      .async_in({chip_select_n, conversion_start_n, read_n, power_down_n,
                 shutdown_depth_select}),
      .sync_out(pins_s)
   );
   wire cs_n_s = pins_s[4];
   wire start_n_s = pins_s[3];
   wire rd_n_s = pins_s[2];
   wire pd_n_s = pins_s[1];
   wire depth_s = pins_s[0];

   sac_state_e state_q, state_d;
   logic start_prev_q;
   logic [3:0] bit_q, bit_d;
   logic [7:0] tick_q, tick_d;
   logic [RES_BITS-1:0] sar_q, sar_d;
   logic [RES_BITS-1:0] latch_q;
   logic [1:0] pwr_q;

   wire powered = (pwr_q == SAC_PWR_ON);
   wire start_edge = start_prev_q && !start_n_s && !cs_n_s;
   wire start_go = start_edge && powered && (state_q == SAC_ACQUIRE);
   wire tick_done = (state_q == SAC_CONVERT) ? (tick_q == BIT_LAST) : (tick_q == LEAD_LAST);
   wire bit_last = (bit_q == 4'h0);
   wire drive_en = !rd_n_s && !cs_n_s;
   wire [1:0] pwr_sel = !pd_n_s ? (depth_s ? 2'(SAC_PWR_NAP) : 2'(SAC_PWR_SLEEP))
                                : 2'(SAC_PWR_ON);

   // trial bit of the current decision, msb first
   wire [RES_BITS-1:0] trial_mask = {{(RES_BITS-1){1'b0}}, 1'b1} << bit_q;
   wire [RES_BITS-1:0] sar_keep = comparator_high ? sar_q : (sar_q & ~trial_mask);
   wire [RES_BITS-1:0] next_trial = bit_last ? sar_keep : (sar_keep | (trial_mask >> 1));

   always_comb begin
      state_d = state_q;
      bit_d = bit_q;
      tick_d = tick_q;
      sar_d = sar_q;
      case (state_q)
         SAC_ACQUIRE: begin
            if (start_go) begin
               state_d = SAC_CONVERT;
               bit_d = LAST_BIT;
               tick_d = 8'h00;
               // clear then set the msb trial
               sar_d = {1'b1, {(RES_BITS-1){1'b0}}};
            end
         end
         SAC_CONVERT: begin
            // internal clock paces every decision
            if (tick_done) begin
               tick_d = 8'h00;
               sar_d = next_trial;
               if (bit_last) begin
                  state_d = SAC_LOAD;
               end else begin
                  bit_d = bit_q - 4'h1;
               end
            end else begin
               tick_d = tick_q + 8'h01;
            end
         end
         SAC_LOAD: begin
            state_d = SAC_LEAD;
            tick_d = 8'h00;
         end
         SAC_LEAD: begin
            if (tick_done) begin
               state_d = SAC_ACQUIRE;
            end else begin
               tick_d = tick_q + 8'h01;
            end
         end
         default: state_d = SAC_ACQUIRE;
      endcase
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state_q <= SAC_ACQUIRE;
         bit_q <= 4'h0;
         tick_q <= 8'h00;
         sar_q <= '0;
         start_prev_q <= 1'b1;
         pwr_q <= SAC_PWR_ON;
      end else if (clk_en) begin
         state_q <= state_d;
         bit_q <= bit_d;
         tick_q <= tick_d;
         sar_q <= sar_d;
         start_prev_q <= start_n_s;
         // power changes only between conversions
         if (state_q == SAC_ACQUIRE && !start_go) begin
            pwr_q <= pwr_sel;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         latch_q <= '0;
         busy_n <= 1'b1;
         result_bus_o <= '0;
         result_bus_oe <= '0;
         dac_word <= '0;
         sample_phase <= 1'b1;
         power_mode <= 2'(SAC_PWR_ON);
      end else if (clk_en) begin
         if (state_q == SAC_LOAD) begin
            latch_q <= sar_q;
         end
         busy_n <= (state_d == SAC_ACQUIRE);
         result_bus_o <= (state_q == SAC_LOAD) ? sar_q : latch_q;
         result_bus_oe <= {RES_BITS{drive_en}};
         dac_word <= sar_d;
         sample_phase <= (state_d == SAC_ACQUIRE);
         power_mode <= pwr_q;
      end
   end

   ck_busy_low_a: assert property (@(posedge mclk) disable iff (reset)
      state_q == SAC_CONVERT |-> !busy_n)
      else $error("busy_n high during conversion");
   ck_no_restart_a: assert property (@(posedge mclk) disable iff (reset)
      (state_q == SAC_CONVERT && clk_en && !bit_last) |=> state_q == SAC_CONVERT)
      else $error("conversion left early");
   ck_sar_clear_a: assert property (@(posedge mclk) disable iff (reset)
      (start_go && clk_en) |=> sar_q == `SAC_MID_WORD)
      else $error("approximation not cleared at start");
   ck_bus_drive_a: assert property (@(posedge mclk) disable iff (reset)
      (clk_en && cs_n_s) |=> result_bus_oe == '0)
      else $error("result bus driven with chip select high");
   ck_cs_gate_a: assert property (@(posedge mclk) disable iff (reset)
      (cs_n_s && state_q == SAC_ACQUIRE && clk_en) |=> state_q == SAC_ACQUIRE)
      else $error("start honoured while deselected");
   ck_lead_a: assert property (@(posedge mclk) disable iff (reset)
      $rose(busy_n) |-> $past(state_q) == SAC_LEAD && result_bus_o == latch_q)
      else $error("busy_n rose without data lead");
   ck_latch_a: assert property (@(posedge mclk) disable iff (reset)
      (state_q == SAC_LOAD && clk_en) |=> latch_q == $past(sar_q))
      else $error("output latch not loaded");
   ck_pwr_nap_a: assert property (@(posedge mclk) disable iff (reset)
      (state_q == SAC_ACQUIRE && !start_go && clk_en && !pd_n_s && depth_s)
         |=> pwr_q == SAC_PWR_NAP)
      else $error("nap mode not chosen");
   ck_acquire_a: assert property (@(posedge mclk) disable iff (reset)
      (state_q == SAC_LEAD && tick_done && clk_en) |=> state_q == SAC_ACQUIRE ##1 sample_phase)
      else $error("acquire phase not entered");

   // sequencer, power and bus checks
   ck_start_go_a: assert property (@(posedge mclk) disable iff (reset)
      (start_edge && powered && state_q == SAC_ACQUIRE && clk_en) |=> state_q == SAC_CONVERT)
      else $error("start edge not honoured");
   ck_pwr_block_a: assert property (@(posedge mclk) disable iff (reset)
      (!powered && state_q == SAC_ACQUIRE && clk_en) |=> state_q == SAC_ACQUIRE)
      else $error("start honoured in power-down");
   ck_pwr_sleep_a: assert property (@(posedge mclk) disable iff (reset)
      (state_q == SAC_ACQUIRE && !start_go && clk_en && !pd_n_s && !depth_s)
         |=> pwr_q == SAC_PWR_SLEEP)
      else $error("sleep mode not chosen");
   ck_msb_first_a: assert property (@(posedge mclk) disable iff (reset)
      (state_q == SAC_CONVERT && tick_done && !bit_last && clk_en)
         |=> bit_q == $past(bit_q) - 4'h1)
      else $error("bit order broken");
   ck_bus_on_a: assert property (@(posedge mclk) disable iff (reset)
      (clk_en && drive_en) |=> result_bus_oe == '1)
      else $error("result bus not driven on read");
   ck_rd_gate_a: assert property (@(posedge mclk) disable iff (reset)
      (clk_en && rd_n_s) |=> result_bus_oe == '0)
      else $error("result bus driven without read");
   ck_sample_off_a: assert property (@(posedge mclk) disable iff (reset)
      state_q == SAC_CONVERT |-> !sample_phase)
      else $error("inputs sampled during conversion");
   ck_busy_end_a: assert property (@(posedge mclk) disable iff (reset)
      (state_q == SAC_LEAD && tick_done && clk_en) |=> busy_n)
      else $error("busy_n not released at completion");
   ck_result_hold_a: assert property (@(posedge mclk) disable iff (reset)
      (state_q == SAC_ACQUIRE && clk_en) |=> result_bus_o == $past(latch_q))
      else $error("result latch output not held");
   ck_freeze_a: assert property (@(posedge mclk) disable iff (reset)
      (!clk_en && state_q == SAC_CONVERT) |=> $stable(sar_q) && $stable(tick_q))
      else $error("conversion moved while frozen");
endmodule
`default_nettype wire

// ===== logic/sac_cfg.svh
// constants for the successive-approximation conversion control
// How it works
// - a falling edge on conversion_start_n with chip select low starts a conversion
// - chip select high makes start and read strobe ignored
// - result bus is driven only while read strobe and chip select are both low
// - twelve three-state result lines, highest line is the most significant bit
// - busy_n stays low through a conversion and rises when it completes
// - power_down_n low enters the power-down mode picked by depth select
// - depth select high picks nap mode with quick wake-up
// - the approximation register is cleared at the start of every conversion
// - start requests during a conversion are ignored, never restarting it
// - bits are decided one at a time from msb down to lsb
// - at the end the finished word is copied into the output latches
// - after conversion the block returns to the acquire phase
// - result latches are valid at least 20 ns before busy_n rises
// - output code is straight binary, zero is the all-zeros code (SAC_ZERO_WORD)
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH
`define SAC_RES_BITS 12
`define SAC_CLK_NS 20
`define SAC_LEAD_NS 20
`define SAC_LEAD_CYC ((`SAC_LEAD_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_BIT_CYC 2
`define SAC_ZERO_WORD 12'h000
`define SAC_MID_WORD 12'h800
`define SAC_PIN_IDLE 5'h1f
`endif

// ===== logic/sac_pkg.sv
// types for the conversion control
package sac_pkg;
   typedef enum logic [1:0] {SAC_ACQUIRE, SAC_CONVERT, SAC_LOAD, SAC_LEAD} sac_state_e;
   typedef enum logic [1:0] {SAC_PWR_ON, SAC_PWR_NAP, SAC_PWR_SLEEP} sac_pwr_e;
endpackage

// ===== logic/sac_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module sac_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   initial begin
      if (WIDTH < 1) $error("sac_sync width must be positive");
   end
   // reset value is the idle level of the pins
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         meta_q <= RST_VAL;
         sync_out <= RST_VAL;
      end else if (clk_en) begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ===== verif/sac_host.sv
// host and comparator model facing the conversion control
`timescale 1ns/1ps
`default_nettype none
module sac_host (
   input wire logic mclk,
   input wire logic busy_n,
   input wire logic [11:0] result_bus_o,
   input wire logic [11:0] result_bus_oe,
   input wire logic [11:0] dac_word,
   input wire logic [11:0] target,
   output logic comparator_high,
   output logic [11:0] bus_level,
   output logic [11:0] captured
);
   logic [11:0] last_q = 12'h000;
   logic busy_q = 1'b1;
   // keep the trial bit while the dac is not above the input
   assign comparator_high = (dac_word <= target);
   // released lines show the inverse of their last driven value
   assign bus_level = (result_bus_o & result_bus_oe) | (~last_q & ~result_bus_oe);
   always @(posedge mclk) begin
      last_q <= (result_bus_o & result_bus_oe) | (last_q & ~result_bus_oe);
      busy_q <= busy_n;
      if (!busy_q && busy_n) captured <= result_bus_o;
   end
endmodule
`default_nettype wire

// ===== verif/sac_ctrl_tb.sv
// self-checking bench for the conversion control
`include "sac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_tb;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic cs_n = 1'b1;
   logic start_n = 1'b1;
   logic read_n = 1'b1;
   logic pd_n = 1'b1;
   logic depth = 1'b1;
   logic clk_en = 1'b1;
   logic [11:0] target = 12'h000;
   logic busy_n, comp, sample_phase;
   logic [11:0] res_o, res_oe, dac, bus_level, captured;
   logic [1:0] power_mode;
   int err_count = 0;
   int comparisons = 0;
   int lowc = 0;
   int n;
   always #10 mclk = ~mclk;
   always @(negedge mclk) if (busy_n === 1'b0) lowc++;
   sac_ctrl i_sac_ctrl (.mclk(mclk), .reset(reset), .clk_en(clk_en), .chip_select_n(cs_n),
      .conversion_start_n(start_n), .read_n(read_n), .power_down_n(pd_n),
      .shutdown_depth_select(depth), .comparator_high(comp), .busy_n(busy_n),
      .result_bus_o(res_o), .result_bus_oe(res_oe), .dac_word(dac),
      .sample_phase(sample_phase), .power_mode(power_mode));
   sac_host i_sac_host (.mclk(mclk), .busy_n(busy_n), .result_bus_o(res_o),
      .result_bus_oe(res_oe), .dac_word(dac), .target(target), .comparator_high(comp),
      .bus_level(bus_level), .captured(captured));
   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // low for three cycles, well inside the early-release window
   task automatic pulse_start;
      @(negedge mclk) start_n = 1'b0;
      repeat (3) @(negedge mclk);
      start_n = 1'b1;
   endtask
   task automatic conv(input logic [11:0] t, input bit again);
      @(negedge mclk) cs_n = 1'b0;
      target = t;
      lowc = 0;
      repeat (3) @(negedge mclk);
      pulse_start();
      n = 0;
      while (busy_n !== 1'b0 && n < 10) begin @(negedge mclk); n++; end
      chk("busy_fall", 12'h000, {11'h0, busy_n});
      chk("convert_phase", 12'h000, {11'h0, sample_phase});
      if (again) pulse_start();
      n = 0;
      while (busy_n !== 1'b1 && n < 60) begin @(negedge mclk); n++; end
      // host model latches one clock after busy_n rises
      @(negedge mclk);
      chk("busy_len", 12'(12 * `SAC_BIT_CYC + `SAC_LEAD_CYC + 1), 12'(lowc));
      chk("result", t, captured);
      chk("acquire_phase", 12'h001, {11'h0, sample_phase});
      repeat (8) @(negedge mclk);
   endtask
   task automatic cs_ignored;
      @(negedge mclk) cs_n = 1'b1;
      read_n = 1'b0;
      repeat (3) @(negedge mclk);
      pulse_start();
      repeat (6) @(negedge mclk);
      chk("cs_start", 12'h001, {11'h0, busy_n});
      chk("cs_read_oe", 12'h000, res_oe);
      read_n = 1'b1;
   endtask
   task automatic read_back(input logic [11:0] t);
      @(negedge mclk) cs_n = 1'b0;
      read_n = 1'b0;
      repeat (4) @(negedge mclk);
      chk("read_oe", 12'hfff, res_oe);
      chk("read_bus", t, bus_level);
      cs_n = 1'b1;
      repeat (4) @(negedge mclk);
      chk("release_oe", 12'h000, res_oe);
      chk("release_bus", ~t, bus_level);
      read_n = 1'b1;
   endtask
   task automatic power(input logic d, input logic [1:0] mode);
      @(negedge mclk) depth = d;
      cs_n = 1'b0;
      repeat (10) @(negedge mclk);
      pd_n = 1'b0;
      repeat (4) @(negedge mclk);
      chk("pwr_mode", {10'h0, mode}, {10'h0, power_mode});
      pulse_start();
      repeat (6) @(negedge mclk);
      chk("pwr_start", 12'h001, {11'h0, busy_n});
      pd_n = 1'b1;
      repeat (10) @(negedge mclk);
      chk("pwr_on", 12'h000, {10'h0, power_mode});
   endtask
   // clock enable low in the first cycle of a conversion must hold every state
   task automatic freeze_run(input logic [11:0] t);
      logic [11:0] hold;
      @(negedge mclk) target = t;
      lowc = 0;
      repeat (3) @(negedge mclk);
      pulse_start();
      n = 0;
      while (busy_n !== 1'b0 && n < 10) begin
         @(negedge mclk);
         n++;
      end
      clk_en = 1'b0;
      hold = dac;
      repeat (20) @(negedge mclk);
      chk("freeze_busy", 12'h000, {11'h0, busy_n});
      chk("freeze_dac", hold, dac);
      clk_en = 1'b1;
      n = 0;
      while (busy_n !== 1'b1 && n < 80) begin
         @(negedge mclk);
         n++;
      end
      @(negedge mclk);
      chk("freeze_len", 12'(12 * `SAC_BIT_CYC + `SAC_LEAD_CYC + 21), 12'(lowc));
      chk("freeze_result", t, captured);
      repeat (8) @(negedge mclk);
   endtask
   initial begin
      #100000;
      err_count++;
      wrap_up();
   end
   initial begin
      repeat (5) @(negedge mclk);
      reset = 1'b0;
      repeat (2) @(negedge mclk);
      conv(12'hfff, 1'b0);
      conv(12'h000, 1'b0);
      conv(12'h5a3, 1'b1);
      conv(12'h800, 1'b0);
      read_back(12'h800);
      cs_ignored();
      power(1'b1, 2'h1);
      conv(12'h7ff, 1'b0);
      freeze_run(12'h3c6);
      // sleep last: power_mode must read on again ten cycles after power_down_n rises
      power(1'b0, 2'h2);
      wrap_up();
   end
endmodule
`default_nettype wire
